// File: core/swlc_pkg.sv
package swlc_pkg;

	// =====================================================
	// word layout
	localparam int         CODE_W   = 7;
	localparam int         TAPS     = 128;
	localparam int         MSB_IDX  = CODE_W - 1;
	localparam int         CHAIN_N  = 2;
	localparam int         CHAIN_W  = CHAIN_N * CODE_W;

	// =====================================================
	// codes
	localparam logic [6:0] MID_CODE = 7'h40;
	localparam logic [6:0] LOW_CODE = 7'h00;
	localparam logic [6:0] TOP_CODE = 7'h7f;
	// stands in for the undefined power-up setting
	localparam logic [6:0] PWRUP_CODE = 7'h00;

	// =====================================================
	// core clock
	localparam int         CORE_CLK_HZ = 40_000_000;

	// =====================================================
	// control states
	typedef enum logic [1:0] {
		SWLC_IDLE   = 2'b00,
		SWLC_SHIFT  = 2'b01,
		SWLC_PRESET = 2'b10
	} swlc_state_e;

endpackage

// File: core/swlc_tap_decode.sv
`timescale 1ns/1ps
module swlc_tap_decode
	import swlc_pkg::*;
#(
	parameter int CW = CODE_W,
	parameter int NT = TAPS
) (
	input  wire logic          clk,     // core clock
	input  wire logic          rst_n,   // async reset, active low
	input  wire logic          ce,      // clock enable
	input  wire logic [CW-1:0] code,    // wiper code
	output logic      [NT-1:0] tap_sel  // one-hot tap select
);

	localparam logic [NT-1:0] ONE     = NT'(1);
	localparam logic [NT-1:0] TAP_RST = ONE << PWRUP_CODE;

	logic [NT-1:0] tap_nxt;

	// =====================================================
	// decode: code 0 is the lower terminal tap
	always_comb begin
		tap_nxt = ONE << code;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			tap_sel <= TAP_RST;
		end else if (ce) begin
			tap_sel <= tap_nxt;
		end
	end

	// =====================================================
	// checks
	property p_onehot;
		@(posedge clk) disable iff (!rst_n)
		$onehot(tap_sel);
	endproperty
	a_onehot: assert property (p_onehot) else $error("tap select not one-hot");

	property p_tap_map;
		@(posedge clk) disable iff (!rst_n)
		ce |=> tap_sel == (ONE << $past(code));
	endproperty
	a_tap_map: assert property (p_tap_map) else $error("tap does not follow code");

	c_top_tap: cover property (@(posedge clk) disable iff (!rst_n) tap_sel[NT-1]);

endmodule

// File: core/swlc_top.sv
`timescale 1ns/1ps
module swlc_top
	import swlc_pkg::*;
#(
	parameter int CW = CODE_W,
	parameter int NT = TAPS
) (
	input  wire logic          core_clk,        // core clock, 40 MHz
	input  wire logic          rst_n,           // async reset, active low
	input  wire logic          core_ce,         // core clock enable
	input  wire logic          ser_clk,         // serial clock, rising edge
	input  wire logic          select_n,        // frame select, active low
	input  wire logic          serial_in,       // serial data in
	input  wire logic          center_preset_n, // midscale preset, active low
	input  wire logic          sleep_n,         // sleep, active low
	output logic      [CW-1:0] wiper_code,      // held wiper code
	output logic      [NT-1:0] tap_sel,         // one-hot ladder tap
	output logic               upper_open,      // upper terminal opened
	output logic               wiper_to_low,    // wiper tied to lower end
	output logic               chain_out_o,     // chain data, always low
	output logic               chain_out_oe     // chain pull-down enable
);

	// =====================================================
	// link side: shifter and chain latch on ser_clk
	logic [CW-1:0] shifter_r;
	logic [CW-1:0] shifter_nxt;
	logic          chain_bit_r;
	logic          chain_bit_nxt;
	logic          chain_pull_r;
	logic          chain_pull_nxt;
	logic          link_clr_n;

	// preset clears the chain latch with no clock at all
	assign link_clr_n = rst_n & center_preset_n;

	always_comb begin
		shifter_nxt    = {shifter_r[CW-2:0], serial_in};
		chain_bit_nxt  = shifter_r[CW-1];
		chain_pull_nxt = ~shifter_r[CW-1];
	end

	always_ff @(posedge ser_clk or negedge rst_n) begin
		if (!rst_n) begin
			shifter_r <= PWRUP_CODE;
		end else if (!select_n) begin
			shifter_r <= shifter_nxt;
		end
	end

	always_ff @(posedge ser_clk or negedge link_clr_n) begin
		if (!link_clr_n) begin
			chain_bit_r  <= 1'b0;
			chain_pull_r <= 1'b1;
		end else if (!select_n) begin
			chain_bit_r  <= chain_bit_nxt;
			chain_pull_r <= chain_pull_nxt;
		end
	end

	// =====================================================
	// core side: pin synchronisers
	logic sel_m_r;
	logic sel_s_r;
	logic prs_m_r;
	logic prs_s_r;
	logic slp_m_r;
	logic slp_s_r;

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			sel_m_r <= 1'b1;
			sel_s_r <= 1'b1;
			prs_m_r <= 1'b1;
			prs_s_r <= 1'b1;
			slp_m_r <= 1'b1;
			slp_s_r <= 1'b1;
		end else if (core_ce) begin
			sel_m_r <= select_n;
			sel_s_r <= sel_m_r;
			prs_m_r <= center_preset_n;
			prs_s_r <= prs_m_r;
			slp_m_r <= sleep_n;
			slp_s_r <= slp_m_r;
		end
	end

	// =====================================================
	// core side: frame and preset control
	swlc_state_e   state_r;
	swlc_state_e   state_nxt;
	logic [CW-1:0] wiper_r;
	logic [CW-1:0] wiper_nxt;
	logic          load_now;

	// shifter is quiet here: select high stops the shifting edges
	assign load_now = (state_r == SWLC_SHIFT) && sel_s_r && prs_s_r;

	always_comb begin
		state_nxt = state_r;
		wiper_nxt = wiper_r;
		case (state_r)
			SWLC_IDLE: begin
				if (!prs_s_r) begin
					state_nxt = SWLC_PRESET;
				end else if (!sel_s_r) begin
					state_nxt = SWLC_SHIFT;
				end
			end
			SWLC_SHIFT: begin
				if (!prs_s_r) begin
					state_nxt = SWLC_PRESET;
				end else if (sel_s_r) begin
					wiper_nxt = shifter_r;
					state_nxt = SWLC_IDLE;
				end
			end
			SWLC_PRESET: begin
				if (prs_s_r) begin
					if (sel_s_r) begin
						wiper_nxt = MID_CODE;
						state_nxt = SWLC_IDLE;
					end else begin
						state_nxt = SWLC_SHIFT;
					end
				end
			end
			default: begin
				state_nxt = SWLC_IDLE;
			end
		endcase
		if (!prs_s_r) begin
			wiper_nxt = MID_CODE;
		end
	end

	// no sleep term touches the latch
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_r <= SWLC_IDLE;
			wiper_r <= PWRUP_CODE;
		end else if (core_ce) begin
			state_r <= state_nxt;
			wiper_r <= wiper_nxt;
		end
	end

	// =====================================================
	// core side: terminal routing and chain driver enable
	logic upper_open_r;
	logic upper_open_nxt;
	logic wiper_low_r;
	logic wiper_low_nxt;
	logic drive_ok_r;
	logic drive_ok_nxt;

	always_comb begin
		upper_open_nxt = ~slp_s_r;
		wiper_low_nxt  = ~slp_s_r;
		drive_ok_nxt   = ~sel_s_r & slp_s_r & prs_s_r;
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			upper_open_r <= 1'b0;
			wiper_low_r  <= 1'b0;
			drive_ok_r   <= 1'b0;
		end else if (core_ce) begin
			upper_open_r <= upper_open_nxt;
			wiper_low_r  <= wiper_low_nxt;
			drive_ok_r   <= drive_ok_nxt;
		end
	end

	// =====================================================
	// tap decoder
	swlc_tap_decode #(
		.CW (CW),
		.NT (NT)
	) u_decode (
		.clk     (core_clk),
		.rst_n   (rst_n),
		.ce      (core_ce),
		.code    (wiper_r),
		.tap_sel (tap_sel)
	);

	// =====================================================
	// outputs
	assign wiper_code   = wiper_r;
	assign upper_open   = upper_open_r;
	assign wiper_to_low = wiper_low_r;
	// open drain: data is always low, only the enable moves
	assign chain_out_o  = 1'b0;
	assign chain_out_oe = chain_pull_r & drive_ok_r & link_clr_n;

	// =====================================================
	// checks: link side
	property p_shift_in;
		@(posedge ser_clk) disable iff (!rst_n)
		!select_n |=> shifter_r[0] == $past(serial_in);
	endproperty
	a_shift_in: assert property (p_shift_in) else $error("serial bit not captured");

	property p_keep_last;
		@(posedge ser_clk) disable iff (!rst_n)
		(!select_n) [*7] |=> shifter_r == {$past(serial_in, 7), $past(serial_in, 6),
			$past(serial_in, 5), $past(serial_in, 4), $past(serial_in, 3),
			$past(serial_in, 2), $past(serial_in, 1)};
	endproperty
	a_keep_last: assert property (p_keep_last) else $error("shifter lost last seven");

	property p_chain_delay;
		@(posedge ser_clk) disable iff (!link_clr_n)
		(!select_n) [*8] |=> chain_bit_r == $past(serial_in, 8);
	endproperty
	a_chain_delay: assert property (p_chain_delay) else $error("chain bit wrong age");

	property p_hold_shift;
		@(posedge ser_clk) disable iff (!rst_n)
		select_n |=> $stable(shifter_r);
	endproperty
	a_hold_shift: assert property (p_hold_shift) else $error("shift while deselected");

	// preset holds the chain latch cleared whatever the serial clock does
	property p_chain_clr;
		@(posedge ser_clk) disable iff (!rst_n)
		!center_preset_n |-> !chain_bit_r && chain_pull_r;
	endproperty
	a_chain_clr: assert property (p_chain_clr) else $error("chain not cleared");

	property p_chain_idle;
		@(posedge ser_clk) disable iff (!link_clr_n)
		select_n |=> $stable(chain_bit_r) && $stable(chain_pull_r);
	endproperty
	a_chain_idle: assert property (p_chain_idle) else $error("chain moved idle");

	// =====================================================
	// checks: core side
	property p_preset_hold;
		@(posedge core_clk) disable iff (!rst_n)
		(!prs_s_r && core_ce) |=> (wiper_r == MID_CODE) && (state_r == SWLC_PRESET);
	endproperty
	a_preset_hold: assert property (p_preset_hold) else $error("preset not midscale");

	property p_preset_rise;
		@(posedge core_clk) disable iff (!rst_n)
		(state_r == SWLC_PRESET && prs_s_r && sel_s_r && core_ce)
			|=> wiper_r == MID_CODE ##1 (tap_sel == (NT'(1) << MID_CODE)) || !core_ce;
	endproperty
	a_preset_rise: assert property (p_preset_rise) else $error("preset rise load wrong");

	property p_load;
		@(posedge core_clk) disable iff (!rst_n)
		(load_now && core_ce) |=> wiper_r == $past(shifter_r) && state_r == SWLC_IDLE;
	endproperty
	a_load: assert property (p_load) else $error("select rise did not load");

	property p_idle_quiet;
		@(posedge core_clk) disable iff (!rst_n)
		(state_r == SWLC_IDLE && prs_s_r) |=> $stable(wiper_r);
	endproperty
	a_idle_quiet: assert property (p_idle_quiet) else $error("latch moved while idle");

	property p_sleep_route;
		@(posedge core_clk) disable iff (!rst_n)
		(!slp_s_r && core_ce) |=> upper_open && wiper_to_low && !chain_out_oe;
	endproperty
	a_sleep_route: assert property (p_sleep_route) else $error("sleep routing wrong");

	property p_sleep_keep;
		@(posedge core_clk) disable iff (!rst_n)
		($rose(slp_s_r) && state_r == SWLC_IDLE && prs_s_r) |=> $stable(wiper_r);
	endproperty
	a_sleep_keep: assert property (p_sleep_keep) else $error("wake changed wiper");

	property p_no_high;
		@(posedge core_clk) disable iff (!rst_n)
		chain_out_o == 1'b0;
	endproperty
	a_no_high: assert property (p_no_high) else $error("chain driven high");

	property p_drive_gate;
		@(posedge core_clk) disable iff (!rst_n)
		chain_out_oe |-> $past(!sel_s_r) && $past(slp_s_r) && center_preset_n;
	endproperty
	a_drive_gate: assert property (p_drive_gate) else $error("chain enabled out of frame");

	// the pin itself gates the driver, ahead of the synchroniser
	property p_prs_oe_off;
		@(posedge core_clk) disable iff (!rst_n)
		!center_preset_n |-> !chain_out_oe;
	endproperty
	a_prs_oe_off: assert property (p_prs_oe_off) else $error("oe on in preset");

	property p_wake_route;
		@(posedge core_clk) disable iff (!rst_n)
		(slp_s_r && core_ce) |=> !upper_open && !wiper_to_low;
	endproperty
	a_wake_route: assert property (p_wake_route) else $error("wake routing wrong");

	property p_sleep_enter;
		@(posedge core_clk) disable iff (!rst_n)
		($fell(slp_s_r) && state_r == SWLC_IDLE && prs_s_r) |=> $stable(wiper_r);
	endproperty
	a_sleep_enter: assert property (p_sleep_enter) else $error("sleep moved wiper");

	property p_frame_start;
		@(posedge core_clk) disable iff (!rst_n)
		(state_r == SWLC_IDLE && prs_s_r && !sel_s_r && core_ce) |=> state_r == SWLC_SHIFT;
	endproperty
	a_frame_start: assert property (p_frame_start) else $error("frame start missed");

	// preset released inside a frame keeps midscale until the frame ends
	property p_preset_open;
		@(posedge core_clk) disable iff (!rst_n)
		(state_r == SWLC_PRESET && prs_s_r && !sel_s_r && core_ce)
			|=> state_r == SWLC_SHIFT && wiper_r == MID_CODE;
	endproperty
	a_preset_open: assert property (p_preset_open) else $error("preset exit wrong");

	property p_frame_gate;
		@(posedge core_clk) disable iff (!rst_n)
		(!sel_s_r && slp_s_r && prs_s_r && core_ce) |=> drive_ok_r;
	endproperty
	a_frame_gate: assert property (p_frame_gate) else $error("oe gate not open");

	// =====================================================
	// scenarios
	c_load: cover property (@(posedge core_clk) disable iff (!rst_n)
		load_now && core_ce);
	c_preset: cover property (@(posedge core_clk) disable iff (!rst_n)
		state_r == SWLC_PRESET ##1 state_r == SWLC_IDLE);
	c_sleep_write: cover property (@(posedge core_clk) disable iff (!rst_n)
		load_now && !slp_s_r);
	c_chain: cover property (@(posedge ser_clk) disable iff (!rst_n)
		(!select_n) [*8] ##1 chain_bit_r);

endmodule

// File: testbench/swlc_host_model.sv
`timescale 1ns/1ps
module swlc_host_model
	import swlc_pkg::*;
(
	output logic        ser_clk,   // serial clock, low outside frames except during idle_clk
	output logic        select_n,  // frame select, active low
	output logic        serial_in, // serial data to the device
	input  wire logic   chain_oe   // device pull-down enable
);
	logic        chain_line;
	logic [13:0] chain_rx;

	// =====================================================
	// chain line with pull-up
	assign chain_line = chain_oe ? 1'b0 : 1'b1;

	initial begin
		ser_clk = 1'b0;
		select_n = 1'b1;
		serial_in = 1'b0;
		chain_rx = '0;
	end

	// =====================================================
	// framing
	task automatic put(input logic b);
		serial_in = b;
		#3 ser_clk = 1'b1;
		#3 ser_clk = 1'b0;
		chain_rx = {chain_rx[12:0], chain_line};
	endtask

	task automatic open_f();
		#1.3 select_n = 1'b0;
		#100;
	endtask

	task automatic close_f();
		#4 select_n = 1'b1;
		serial_in = ~serial_in;
		#150;
	endtask

	// stray clock edges while deselected, data toggling
	task automatic idle_clk(input int n);
		repeat (n) begin
			serial_in = ~serial_in;
			#3 ser_clk = 1'b1;
			#3 ser_clk = 1'b0;
		end
	endtask

	task automatic frame7(input logic [6:0] w);
		open_f();
		for (int i = 6; i >= 0; i--) begin
			put(w[i]);
		end
		close_f();
	endtask

	task automatic frame14(input logic [13:0] w);
		open_f();
		for (int i = 13; i >= 0; i--) begin
			put(w[i]);
		end
		close_f();
	endtask
endmodule

// File: testbench/tb_top.sv
`timescale 1ns/1ps
module tb_top
	import swlc_pkg::*;
;
	logic         core_clk, rst_n, core_ce, center_preset_n, sleep_n;
	logic         ser_clk, select_n, serial_in;
	logic [6:0]   wiper_code;
	logic [127:0] tap_sel;
	logic         upper_open, wiper_to_low, chain_out_o, chain_out_oe;
	int           n_errors, n_compared, cyc;

	swlc_top i_swlc_top (
		.core_clk(core_clk), .rst_n(rst_n), .core_ce(core_ce), .ser_clk(ser_clk),
		.select_n(select_n), .serial_in(serial_in), .center_preset_n(center_preset_n),
		.sleep_n(sleep_n), .wiper_code(wiper_code), .tap_sel(tap_sel),
		.upper_open(upper_open), .wiper_to_low(wiper_to_low),
		.chain_out_o(chain_out_o), .chain_out_oe(chain_out_oe)
	);

	swlc_host_model u_host (
		.ser_clk(ser_clk), .select_n(select_n), .serial_in(serial_in),
		.chain_oe(chain_out_oe)
	);

	always #12.5 core_clk = ~core_clk;

	// =====================================================
	// helpers
	task automatic end_sim();
		if (n_errors == 0 && n_compared > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	always @(posedge core_clk) begin
		cyc++;
		if (cyc >= 20000) begin
			n_errors++;
			end_sim();
		end
	end

	task automatic wait_cyc(input int n);
		repeat (n) @(negedge core_clk);
	endtask

	task automatic chk(input logic [127:0] got, input logic [127:0] exp);
		n_compared++;
		if (got !== exp) begin
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
			n_errors++;
		end
	endtask

	// =====================================================
	// scenarios
	task automatic t_reset();
		chk(wiper_code, PWRUP_CODE);
		chk(tap_sel, 128'h1);
		chk(chain_out_oe, 1'b0);
		chk(chain_out_o, 1'b0);
	endtask

	task automatic t_writes();
		logic [6:0] codes [6];
		codes = '{7'h00, 7'h01, 7'h40, 7'h7f, 7'h55, 7'h2a};
		for (int i = 0; i < 6; i++) begin
			u_host.frame7(codes[i]);
			wait_cyc(2);
			chk(wiper_code, codes[i]);
			chk(tap_sel, 128'h1 << codes[i]);
			chk(chain_out_oe, 1'b0);
			if (i > 0) begin
				chk(u_host.chain_rx[6:0], codes[i-1]);
			end
		end
	endtask

	task automatic t_long();
		u_host.idle_clk(5);
		wait_cyc(4);
		chk(wiper_code, 7'h2a);
		u_host.frame14({7'h13, 7'h6c});
		wait_cyc(2);
		chk(wiper_code, 7'h6c);
		chk(u_host.chain_rx, {7'h2a, 7'h13});
	endtask

	task automatic t_preset();
		center_preset_n = 1'b0;
		wait_cyc(5);
		chk(wiper_code, MID_CODE);
		chk(chain_out_oe, 1'b0);
		u_host.frame7(7'h11);
		wait_cyc(1);
		chk(wiper_code, MID_CODE);
		chk(u_host.chain_rx[6:0], 7'h7f);
		center_preset_n = 1'b1;
		wait_cyc(5);
		chk(wiper_code, 7'h40);
	endtask

	task automatic t_sleep();
		sleep_n = 1'b0;
		wait_cyc(5);
		chk({upper_open, wiper_to_low}, 2'b11);
		chk(wiper_code, 7'h40);
		u_host.frame7(7'h21);
		wait_cyc(1);
		chk(u_host.chain_rx[6:0], 7'h7f);
		chk(wiper_code, 7'h21);
		sleep_n = 1'b1;
		wait_cyc(5);
		chk({upper_open, wiper_to_low}, 2'b00);
		chk(tap_sel, 128'h1 << 7'h21);
		sleep_n = 1'b0;
		wait_cyc(5);
		chk(wiper_code, 7'h21);
		sleep_n = 1'b1;
		wait_cyc(5);
		chk(wiper_code, 7'h21);
		chk({upper_open, wiper_to_low}, 2'b00);
	endtask

	// =====================================================
	// main sequence
	initial begin
		core_clk = 1'b0;
		rst_n = 1'b0;
		core_ce = 1'b1;
		center_preset_n = 1'b1;
		sleep_n = 1'b1;
		n_errors = 0;
		n_compared = 0;
		cyc = 0;
		wait_cyc(16);
		rst_n = 1'b1;
		wait_cyc(3);
		t_reset();
		t_writes();
		t_long();
		t_preset();
		t_sleep();
		end_sim();
	end
endmodule
